// ===== design/gmx_pkg.sv
package gmx_pkg;

  // ****************************************************************
  // Port and pin layout
  // ****************************************************************
  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_F = 3'h5;
  localparam logic [2:0] PORT_G = 3'h6;
  localparam logic [2:0] PORT_H = 3'h7;

  // Implemented pins per port, ordered H, G, F, E, D, C, B, A.
  localparam logic [7:0][7:0] PORT_PIN_MASK =
    {8'h0F, 8'h02, 8'h02, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  // Ports whose interrupt uses one selectable edge; the rest use both edges.
  localparam logic [7:0] SINGLE_EDGE_PORTS = 8'h05;

  // Clock edges after reset until the history stage holds a real pin sample.
  localparam logic [1:0] SYNC_FILL_EDGES = 2'h3;

  // ****************************************************************
  // Function select codes and reset values
  // ****************************************************************
  localparam logic [1:0] FSEL_PORT = 2'h0;
  localparam logic [1:0] FSEL_ALT1 = 2'h1;
  localparam logic [1:0] FSEL_ALT2 = 2'h2;
  localparam logic [1:0] FSEL_ALT3 = 2'h3;

  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] OUT_RESET = 8'h00;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0]      port_direction;
    logic [7:0]      port_output_value;
    logic [7:0][1:0] fsel;
    logic [7:0]      edge_rising;
  } gmx_port_cfg_t;

  // Signals that peripherals drive towards the pins.
  typedef struct packed {
    logic timer0_io;            logic timer0_io_oe;
    logic timer0_output;
    logic uart0_driver_enable;
    logic uart0_transmit;
    logic i2c_scl;              logic i2c_scl_oe;
    logic i2c_sda;              logic i2c_sda_oe;
    logic spi_ss;               logic spi_ss_oe;
    logic spi_sck;              logic spi_sck_oe;
    logic spi_mosi;             logic spi_mosi_oe;
    logic spi_miso;             logic spi_miso_oe;
    logic timer1_io;            logic timer1_io_oe;
    logic timer1_output;
    logic comparator_output;
    logic timer2_io;            logic timer2_io_oe;
    logic timer2_output;
    logic pwm_high_0;           logic pwm_low_0;
    logic pwm_high_1;           logic pwm_low_1;
    logic pwm_high_2;           logic pwm_low_2;
    logic uart1_driver_enable;
    logic uart1_transmit;
  } gmx_periph_out_t;

  // Pin levels handed to peripherals.
  typedef struct packed {
    logic timer0_io;
    logic timer0_input_b;
    logic fault_input_1;
    logic fault_input_0;
    logic uart0_clear_to_send;
    logic uart0_receive;
    logic i2c_scl;
    logic i2c_sda;
    logic spi_ss;
    logic spi_sck;
    logic spi_mosi;
    logic spi_miso;
    logic timer1_io;
    logic timer2_io;
    logic uart1_receive;
    logic uart1_clear_to_send;
  } gmx_periph_in_t;

  typedef struct packed {
    logic [11:0] analog_channel;
    logic        opamp_output;
    logic        opamp_positive_input;
    logic        opamp_negative_input;
    logic        comparator_negative_input;
    logic        comparator_positive_input;
  } gmx_analog_t;

  typedef struct packed {
    logic valid;
    logic o;
    logic oe;
    logic analog;
  } gmx_alt_t;

endpackage : gmx_pkg

// ===== design/gmx_pin_sync.sv
`timescale 1ns/1ns

module gmx_pin_sync
  import gmx_pkg::*;
(
  input  wire logic             clock_in,
  input  wire logic             rst_b_in,
  input  wire logic [7:0][7:0]  pin_in,
  output logic      [7:0][7:0]  level_out,
  output logic      [7:0][7:0]  prev_out
);

  // ****************************************************************
  // Two-stage synchroniser plus one history stage
  // ****************************************************************
  typedef struct packed {
    logic [7:0][7:0] meta;
    logic [7:0][7:0] sync;
    logic [7:0][7:0] prev;
  } gmx_sync_state_t;

  gmx_sync_state_t st;
  gmx_sync_state_t next_st;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_st      = st;
    next_st.meta = pin_in;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign level_out = st.sync;
  assign prev_out  = st.prev;

endmodule : gmx_pin_sync

// ===== design/gmx_pin_mux.sv
// What this block does
// - Ports A-E have pins 7..0, port H pins 3..0, ports F and G pin 1.
// - Every pin has its own select; on ports A-D and H it chooses port operation or an alternate function, ports E-G stay in port operation.
// - A selected alternate function controls pin direction instead of the direction bit.
// - Port A maps timer0, UART0, fault inputs and I2C as alternates.
// - Port B and H pins carry analog channels and op-amp/comparator nodes.
// - Port C maps timer1, comparator, SPI, timer2 and PWM pair 0.
// - Port D maps PWM pairs 1 and 2 and UART1 signals.
// - Some pins request an interrupt on one selectable edge.
// - Other pins request an interrupt on both edges.
// - Direction 1 means input, driver off, value sampled; all pins start as inputs.
// - Port output data drives a pin only as output and without alternate function.
`timescale 1ns/1ns

module gmx_pin_mux
  import gmx_pkg::*;
(
  input  wire logic                  clock_in,
  input  wire logic                  rst_b_in,
  input  wire gmx_port_cfg_t [7:0]   port_cfg_in,
  input  wire gmx_periph_out_t       periph_out_in,
  input  wire logic     [7:0][7:0]   pin_in,
  output logic          [7:0][7:0]   pin_out,
  output logic          [7:0][7:0]   pin_oe_out,
  output logic          [7:0][7:0]   port_input_value_out,
  output logic          [7:0][7:0]   irq_req_out,
  output gmx_periph_in_t             periph_in_out,
  output gmx_analog_t                analog_en_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0][7:0] pin_out;
    logic [7:0][7:0] pin_oe;
    logic [7:0][7:0] port_input;
    logic [7:0][7:0] irq;
    logic [7:0][7:0] analog;
    gmx_periph_in_t  periph_in;
    logic [1:0]      fill;
  } gmx_mux_state_t;

  gmx_mux_state_t  st;
  gmx_mux_state_t  next_st;
  logic [7:0][7:0] sync_level;
  logic [7:0][7:0] sync_prev;

  gmx_pin_sync u_sync
  (
    .clock_in  (clock_in),
    .rst_b_in  (rst_b_in),
    .pin_in    (pin_in),
    .level_out (sync_level),
    .prev_out  (sync_prev)
  );

  // ****************************************************************
  // Alternate function table
  // ****************************************************************
  function automatic gmx_alt_t drv(input logic o, input logic oe);
    gmx_alt_t r;
    r.valid  = 1'b1;
    r.o      = o;
    r.oe     = oe;
    r.analog = 1'b0;
    return r;
  endfunction : drv

  function automatic gmx_alt_t ana();
    gmx_alt_t r;
    r        = drv(1'b0, 1'b0);
    r.analog = 1'b1;
    return r;
  endfunction : ana

  // Returns valid=0 when the select code has no function on that pin, in
  // which case the pin keeps ordinary port behaviour.
  function automatic gmx_alt_t alt_map(input logic [2:0] port,
                                       input logic [2:0] bitn,
                                       input logic [1:0] fsel,
                                       input gmx_periph_out_t po);
    gmx_alt_t r;
    logic     f1;
    logic     f2;
    logic     f3;
    r  = '0;
    f1 = (fsel == FSEL_ALT1);
    f2 = (fsel == FSEL_ALT2);
    f3 = (fsel == FSEL_ALT3);
    unique case (port)
      PORT_A:
        unique case (bitn)
          3'h0:    if (f1) r = drv(po.timer0_io, po.timer0_io_oe);
                   else if (f3) r = drv(1'b0, 1'b0);
          3'h1:    if (f1) r = drv(po.timer0_output, 1'b1);
          3'h2:    if (f1) r = drv(po.uart0_driver_enable, 1'b1);
                   else if (f2) r = drv(1'b0, 1'b0);
          3'h3:    if (f1 || f2) r = drv(1'b0, 1'b0);
          3'h4:    if (f1) r = drv(1'b0, 1'b0);
          3'h5:    if (f1) r = drv(po.uart0_transmit, 1'b1);
          3'h6:    if (f1) r = drv(po.i2c_scl, po.i2c_scl_oe);
          default: if (f1) r = drv(po.i2c_sda, po.i2c_sda_oe);
        endcase
      PORT_B, PORT_H:
        if (f1) r = ana();
      PORT_C:
        unique case (bitn)
          3'h0:    if (f1) r = drv(po.timer1_io, po.timer1_io_oe);
                   else if (f3) r = ana();
          3'h1:    if (f1) r = drv(po.timer1_output, 1'b1);
                   else if (f3) r = drv(po.comparator_output, 1'b1);
          3'h2:    if (f1) r = drv(po.spi_ss, po.spi_ss_oe);
          3'h3:    if (f1) r = drv(po.spi_sck, po.spi_sck_oe);
          3'h4:    if (f1) r = drv(po.spi_mosi, po.spi_mosi_oe);
          3'h5:    if (f1) r = drv(po.spi_miso, po.spi_miso_oe);
          3'h6:    if (f1) r = drv(po.timer2_io, po.timer2_io_oe);
                   else if (f2) r = drv(po.pwm_high_0, 1'b1);
          default: if (f1) r = drv(po.timer2_output, 1'b1);
                   else if (f2) r = drv(po.pwm_low_0, 1'b1);
        endcase
      PORT_D:
        unique case (bitn)
          3'h0:    if (f1) r = drv(po.pwm_high_1, 1'b1);
          3'h1:    if (f1) r = drv(po.pwm_low_1, 1'b1);
          3'h2:    if (f1) r = drv(po.pwm_high_2, 1'b1);
          3'h3:    if (f1) r = drv(po.uart1_driver_enable, 1'b1);
          3'h4:    if (f1) r = drv(1'b0, 1'b0);
          3'h5:    if (f1) r = drv(po.uart1_transmit, 1'b1);
          3'h6:    if (f1) r = drv(1'b0, 1'b0);
          default: if (f1) r = drv(po.pwm_low_2, 1'b1);
        endcase
      default:
        r = '0;
    endcase
    return r;
  endfunction : alt_map

  // Pin level handed to a peripheral input, or its idle level when the pin
  // is not assigned to that function.
  function automatic logic route(input gmx_port_cfg_t [7:0] cfg,
                                 input logic [7:0][7:0]    lvl,
                                 input logic [2:0]         port,
                                 input logic [2:0]         bitn,
                                 input logic [1:0]         code,
                                 input logic               idle);
    return (cfg[port].fsel[bitn] == code) ? lvl[port][bitn] : idle;
  endfunction : route

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    gmx_alt_t a;
    logic     rise;
    logic     fall;
    a       = '0;
    rise    = 1'b0;
    fall    = 1'b0;
    next_st = '0;
    // Reset values in the sync stages would look like pin edges, so requests
    // wait until the history stage has seen a real sample.
    next_st.fill = (st.fill == SYNC_FILL_EDGES) ? st.fill : st.fill + 2'h1;
    for (int p = 0; p < 8; p++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (PORT_PIN_MASK[p][b])
        begin
          a = alt_map(3'(p), 3'(b), port_cfg_in[p].fsel[b], periph_out_in);
          if (a.valid)
          begin
            next_st.pin_oe[p][b]  = a.oe;
            next_st.pin_out[p][b] = a.o;
            next_st.analog[p][b]  = a.analog;
          end
          else
          begin
            next_st.pin_oe[p][b]  = ~port_cfg_in[p].port_direction[b];
            next_st.pin_out[p][b] = port_cfg_in[p].port_output_value[b];
          end
          next_st.port_input[p][b] = sync_level[p][b];
          rise = sync_level[p][b] & ~sync_prev[p][b];
          fall = ~sync_level[p][b] & sync_prev[p][b];
          if (st.fill != SYNC_FILL_EDGES)
            next_st.irq[p][b] = 1'b0;
          else if (SINGLE_EDGE_PORTS[p])
            next_st.irq[p][b] = port_cfg_in[p].edge_rising[b] ? rise : fall;
          else
            next_st.irq[p][b] = rise | fall;
        end
      end
    end
    next_st.periph_in.timer0_io           =
      route(port_cfg_in, sync_level, PORT_A, 3'h0, FSEL_ALT1, 1'b0);
    next_st.periph_in.timer0_input_b      =
      route(port_cfg_in, sync_level, PORT_A, 3'h0, FSEL_ALT3, 1'b0);
    next_st.periph_in.fault_input_1       =
      route(port_cfg_in, sync_level, PORT_A, 3'h2, FSEL_ALT2, 1'b0);
    next_st.periph_in.uart0_clear_to_send =
      route(port_cfg_in, sync_level, PORT_A, 3'h3, FSEL_ALT1, 1'b0);
    next_st.periph_in.fault_input_0       =
      route(port_cfg_in, sync_level, PORT_A, 3'h3, FSEL_ALT2, 1'b0);
    next_st.periph_in.uart0_receive       =
      route(port_cfg_in, sync_level, PORT_A, 3'h4, FSEL_ALT1, 1'b1);
    next_st.periph_in.i2c_scl             =
      route(port_cfg_in, sync_level, PORT_A, 3'h6, FSEL_ALT1, 1'b1);
    next_st.periph_in.i2c_sda             =
      route(port_cfg_in, sync_level, PORT_A, 3'h7, FSEL_ALT1, 1'b1);
    next_st.periph_in.timer1_io           =
      route(port_cfg_in, sync_level, PORT_C, 3'h0, FSEL_ALT1, 1'b0);
    next_st.periph_in.spi_ss              =
      route(port_cfg_in, sync_level, PORT_C, 3'h2, FSEL_ALT1, 1'b1);
    next_st.periph_in.spi_sck             =
      route(port_cfg_in, sync_level, PORT_C, 3'h3, FSEL_ALT1, 1'b0);
    next_st.periph_in.spi_mosi            =
      route(port_cfg_in, sync_level, PORT_C, 3'h4, FSEL_ALT1, 1'b0);
    next_st.periph_in.spi_miso            =
      route(port_cfg_in, sync_level, PORT_C, 3'h5, FSEL_ALT1, 1'b0);
    next_st.periph_in.timer2_io           =
      route(port_cfg_in, sync_level, PORT_C, 3'h6, FSEL_ALT1, 1'b0);
    next_st.periph_in.uart1_receive       =
      route(port_cfg_in, sync_level, PORT_D, 3'h4, FSEL_ALT1, 1'b1);
    next_st.periph_in.uart1_clear_to_send =
      route(port_cfg_in, sync_level, PORT_D, 3'h6, FSEL_ALT1, 1'b0);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset leaves every driver off, so all pins come up as inputs.
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      st <= '0;
    else
      st <= next_st;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pin_out              = st.pin_out;
  assign pin_oe_out           = st.pin_oe;
  assign port_input_value_out = st.port_input;
  assign irq_req_out          = st.irq;
  assign periph_in_out        = st.periph_in;

  assign analog_en_out.analog_channel            = {st.analog[PORT_H][3:0],
                                                    st.analog[PORT_B]};
  assign analog_en_out.opamp_output              = st.analog[PORT_B][3];
  assign analog_en_out.opamp_positive_input      = st.analog[PORT_B][6];
  assign analog_en_out.opamp_negative_input      = st.analog[PORT_B][7];
  assign analog_en_out.comparator_negative_input = st.analog[PORT_B][6] |
                                                   st.analog[PORT_C][0];
  assign analog_en_out.comparator_positive_input = st.analog[PORT_H][3];

endmodule : gmx_pin_mux

// ===== verif/gmx_mux_assertions.sv
`timescale 1ns/1ns
module gmx_mux_checker
  import gmx_pkg::*;
(
  input wire logic                clock_in,
  input wire logic                rst_b_in,
  input wire gmx_port_cfg_t [7:0] port_cfg_in,
  input wire gmx_periph_out_t     periph_out_in,
  input wire logic [7:0][7:0]     pin_in,
  input wire logic [7:0][7:0]     pin_out,
  input wire logic [7:0][7:0]     pin_oe_out,
  input wire logic [7:0][7:0]     port_input_value_out,
  input wire logic [7:0][7:0]     irq_req_out,
  input wire gmx_periph_in_t      periph_in_out,
  input wire gmx_analog_t         analog_en_out
);
  gmx_port_cfg_t [7:0]  cfg_q;
  gmx_periph_out_t      po_q;
  logic [3:0][7:0][7:0] hist;
  logic [2:0]           run_cnt;
  logic                 pm_bad;
  logic                 ghost_bad;
  logic [7:0][7:0]      irq_exp;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  // ********
  // Reference pipeline matching the two sync stages and the output register.
  // ********
  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      run_cnt <= 3'h0;
      hist    <= '0;
      cfg_q   <= '0;
      po_q    <= '0;
    end
    else
    begin
      run_cnt <= (run_cnt == 3'h7) ? run_cnt : run_cnt + 3'h1;
      hist    <= {hist[2:0], pin_in};
      cfg_q   <= port_cfg_in;
      po_q    <= periph_out_in;
    end

  always_comb
  begin
    pm_bad    = 1'b0;
    ghost_bad = 1'b0;
    for (int p = 0; p < 8; p++)
      for (int b = 0; b < 8; b++)
      begin
        if (!PORT_PIN_MASK[p][b])
          ghost_bad |= pin_out[p][b] | pin_oe_out[p][b] | irq_req_out[p][b];
        else if (cfg_q[p].fsel[b] == FSEL_PORT || p inside {4, 5, 6})
        begin
          pm_bad |= (pin_oe_out[p][b] != !cfg_q[p].port_direction[b]);
          pm_bad |= pin_oe_out[p][b] & (pin_out[p][b] != cfg_q[p].port_output_value[b]);
        end
        irq_exp[p][b] = PORT_PIN_MASK[p][b] & (hist[2][p][b] ^ hist[3][p][b]);
        if (SINGLE_EDGE_PORTS[p])
          irq_exp[p][b] &= (hist[2][p][b] == cfg_q[p].edge_rising[b]);
      end
  end

  sequence s_live;
    run_cnt != 3'h0;
  endsequence
  sequence s_settled;
    run_cnt == 3'h7;
  endsequence

  AST_RESET_UNDRIVEN : assert property (
    $rose(rst_b_in) |-> pin_oe_out == '0 && irq_req_out == '0) else $error("drive after reset");
  AST_GHOST_PINS : assert property (
    !ghost_bad) else $error("absent pin active");
  AST_PORT_MODE : assert property (
    s_live |-> !pm_bad) else $error("port mode drive wrong");
  AST_IRQ_EDGES : assert property (
    s_settled |-> irq_req_out == irq_exp) else $error("edge request wrong");
  AST_INPUT_SAMPLE : assert property (
    s_settled |-> port_input_value_out == (hist[2] & PORT_PIN_MASK)) else $error("input value wrong");
  AST_ALT_TX : assert property (
    s_live ##0 cfg_q[0].fsel[5] == FSEL_ALT1 |-> pin_oe_out[0][5]
      && pin_out[0][5] == po_q.uart0_transmit) else $error("uart tx pin wrong");
  AST_SPI_OE : assert property (
    s_live ##0 cfg_q[2].fsel[4] == FSEL_ALT1 |-> pin_oe_out[2][4] == po_q.spi_mosi_oe)
    else $error("spi enable wrong");
  AST_ANALOG_B : assert property (
    s_live ##0 cfg_q[1].fsel[3] == FSEL_ALT1 |-> analog_en_out.analog_channel[3]
      && !pin_oe_out[1][3]) else $error("analog pin wrong");
  AST_RX_IDLE : assert property (
    s_settled |-> periph_in_out.uart0_receive == (cfg_q[0].fsel[4] == FSEL_ALT1
      ? hist[2][0][4] : 1'b1)) else $error("uart rx level wrong");
endmodule : gmx_mux_checker

bind gmx_pin_mux gmx_mux_checker chk (.clock_in, .rst_b_in, .port_cfg_in, .periph_out_in,
  .pin_in, .pin_out, .pin_oe_out, .port_input_value_out, .irq_req_out, .periph_in_out,
  .analog_en_out);

// ===== verif/gmx_pin_model.sv
`timescale 1ns/1ns
module gmx_pin_model
(
  input  wire logic [7:0][7:0] drive_in,
  input  wire logic [7:0][7:0] enable_in,
  input  wire logic [7:0][7:0] ext_in,
  output logic      [7:0][7:0] level_out
);
  // A pin follows the block while it drives, otherwise the outside world.
  assign level_out = (drive_in & enable_in) | (ext_in & ~enable_in);
endmodule : gmx_pin_model

// ===== verif/tb_gpio_pin_function_mux.sv
`timescale 1ns/1ns
module tb_gpio_pin_function_mux
  import gmx_pkg::*;
;
  logic                clock_in;
  logic                rst_b_in;
  gmx_port_cfg_t [7:0] cfg;
  gmx_periph_out_t     po;
  gmx_periph_in_t      to_periph;
  gmx_analog_t         ana;
  logic [7:0][7:0]     ext, lvl, pout, oe, val, irq;
  logic [7:0]          n;
  int                  errors, total_checks;

  gmx_pin_mux dut (.clock_in, .rst_b_in, .port_cfg_in(cfg), .periph_out_in(po), .pin_in(lvl),
    .pin_out(pout), .pin_oe_out(oe), .port_input_value_out(val), .irq_req_out(irq),
    .periph_in_out(to_periph), .analog_en_out(ana));
  gmx_pin_model pins (.drive_in(pout), .enable_in(oe), .ext_in(ext), .level_out(lvl));

  // ********
  // Helpers.
  // ********
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic settle(input int cycles);
    repeat (cycles) @(posedge clock_in);
    #1;
  endtask : settle

  // Drives one outside pin level and counts request pulses afterwards.
  task automatic toggle(input int p, input int b, input logic v);
    n = 8'h00;
    @(posedge clock_in);
    ext[p][b] <= v;
    repeat (8)
    begin
      settle(1);
      n += {7'h00, irq[p][b]};
    end
  endtask : toggle

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic t_reset;
    n = 8'h00;
    repeat (4)
    begin
      settle(1);
      n |= 8'(irq != '0);
    end
    check("irq", 8'h00, n);
    check("oe", 8'h00, 8'(oe != '0));
    for (int p = 0; p < 8; p++)
      check("in", PORT_PIN_MASK[p], val[p]);
    $display("done reset");
  endtask : t_reset

  task automatic t_port;
    @(posedge clock_in);
    cfg[0].port_direction    <= 8'h0F;
    cfg[0].port_output_value <= 8'hA5;
    cfg[4].port_direction    <= 8'h00;
    cfg[4].port_output_value <= 8'h3C;
    cfg[4].fsel              <= '1;
    cfg[5].port_direction    <= 8'h00;
    cfg[5].port_output_value <= 8'hFF;
    cfg[5].fsel              <= '1;
    settle(2);
    check("oe_a", 8'hF0, oe[0]);
    check("out_a", 8'hA0, pout[0] & oe[0]);
    check("oe_e", 8'hFF, oe[4]);
    check("out_e", 8'h3C, pout[4]);
    check("oe_f", 8'h02, oe[5]);
    $display("done port");
  endtask : t_port

  task automatic t_alt;
    @(posedge clock_in);
    cfg[0].fsel[1]   <= FSEL_ALT1;
    cfg[0].fsel[4]   <= FSEL_ALT1;
    cfg[0].fsel[5]   <= FSEL_ALT1;
    cfg[2].fsel[4]   <= FSEL_ALT1;
    cfg[2].fsel[7:6] <= {FSEL_ALT2, FSEL_ALT2};
    cfg[2].fsel[1:0] <= {FSEL_ALT3, FSEL_ALT3};
    po.comparator_output <= 1'b1;
    cfg[3].fsel[0]   <= FSEL_ALT1;
    cfg[1].fsel[3]   <= FSEL_ALT1;
    cfg[7].fsel[3]   <= FSEL_ALT1;
    po.timer0_output <= 1'b1;
    po.uart0_transmit <= 1'b1;
    po.pwm_high_0    <= 1'b1;
    po.pwm_high_1    <= 1'b1;
    po.spi_mosi      <= 1'b1;
    po.spi_mosi_oe   <= 1'b1;
    ext[0][4]        <= 1'b0;
    settle(2);
    check("oe_a", 8'hE2, oe[0]);
    check("out_a", 8'h22, pout[0] & 8'h22);
    check("oe_c", 8'hD2, oe[2]);
    check("out_c", 8'h52, pout[2] & oe[2]);
    check("cmp", 8'h01, {7'h00, ana.comparator_negative_input});
    check("out_d", 8'h01, pout[3] & oe[3]);
    check("oe_b", 8'h00, oe[1]);
    check("ana", 8'h88, {ana.analog_channel[11:8], ana.analog_channel[3:0]});
    settle(3);
    check("rx", 8'h00, {7'h00, to_periph.uart0_receive});
    $display("done alternate");
  endtask : t_alt

  task automatic t_irq;
    @(posedge clock_in);
    cfg[0].edge_rising <= 8'h01;
    toggle(0, 0, 1'b0);
    check("a0_fall", 8'h00, n);
    toggle(0, 0, 1'b1);
    check("a0_rise", 8'h01, n);
    toggle(0, 2, 1'b0);
    check("a2_fall", 8'h01, n);
    toggle(3, 2, 1'b0);
    check("d2_fall", 8'h01, n);
    toggle(3, 2, 1'b1);
    check("d2_rise", 8'h01, n);
    check("d_in", 8'hFF, val[3]);
    $display("done interrupt");
  endtask : t_irq

  // ********
  // Clock, watchdog and main sequence.
  // ********
  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  initial
  begin
    repeat (3000) @(posedge clock_in);
    errors++;
    final_report();
  end

  initial
  begin
    rst_b_in = 1'b0;
    po       = '0;
    ext      = '1;
    for (int p = 0; p < 8; p++)
      cfg[p] = '{port_direction: DIR_RESET, port_output_value: OUT_RESET, default: '0};
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_port();
    t_alt();
    t_irq();
    final_report();
  end
endmodule : tb_gpio_pin_function_mux
